// ==== verilog/xmem_pkg.sv ====
// shared constants for the external memory, boot loader and bus grant block
package xmem_pkg;
  // data memory map
  localparam logic [13:0] INT_DM_BASE   = 14'h3800;
  localparam logic [13:0] INT_DM_WORDS  = 14'h0200;
  localparam logic [13:0] CTRL_BASE     = 14'h3A00;
  localparam int          NUM_ZONES     = 5;
  localparam logic [2:0]  ZONE_WS_RESET = 3'h7;
  localparam logic [2:0]  BOOT_WS_RESET = 3'h3;
  // boot memory: 64K space of 8K pages (large), 32K space of 4K pages (small)
  localparam int          BOOT_ADDR_W   = 16;
  localparam int          PAGE_OFF_W    = 13;
  localparam int          BYTES_PER_WORD = 3;
  localparam int          BOOT_WORDS    = 2048;
  // ahb register byte addresses (chosen)
  localparam logic [7:0]  REG_SYSCTRL   = 8'h00;
  localparam logic [7:0]  REG_WAIT      = 8'h04;
  localparam logic [7:0]  REG_STATUS    = 8'h08;
  localparam logic [7:0]  REG_PMLAST    = 8'h0C;
  // system control fields
  localparam int          SC_PAGE_LSB   = 0;
  localparam int          SC_FORCE_BIT  = 3;
  localparam int          SC_NOHALT_BIT = 4;
  localparam int          SC_BOOTWS_LSB = 8;
  localparam int          SC_SMALL_BIT  = 12;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  // zone of a data address: top three address bits select one of five zones
  function automatic logic [2:0] zone_of(input logic [13:0] a);
    logic [2:0] z;
    z = a[13:11];
    if (z > 3'h4) z = 3'h4;
    return z;
  endfunction
endpackage

// ==== verilog/wait_counter.sv ====
// wait state counter for one external access
`timescale 1ns/10ps
`default_nettype none
module wait_counter (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // control
  input  wire logic       start,
  input  wire logic [2:0] waits,
  // status
  output logic            done
);
  logic [3:0] cnt_q;
  logic       busy_q;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_q  <= 4'h0;
      busy_q <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_q  <= {1'b0, waits};
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (cnt_q == 4'h0) begin
          busy_q <= 1'b0;
          done   <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 4'h1;
        end
      end
    end
  end
endmodule // wait_counter
`default_nettype wire

// ==== verilog/boot_loader_and_bus_grant.sv ====
// boot loader, data zone wait states and external bus grant
`timescale 1ns/10ps
`default_nettype none
module boot_loader_and_bus_grant
  import xmem_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // reset pin level and map strap (asynchronous pins)
  input  wire logic        reset_pin_n,
  input  wire logic        memory_map_select,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // core external access request
  input  wire logic        core_req,
  input  wire logic        core_pm,
  input  wire logic        core_write,
  input  wire logic [13:0] core_addr,
  input  wire logic [23:0] core_wdata,
  output logic             core_done,
  output logic [23:0]      core_rdata,
  output logic             core_halt,
  // bus arbitration
  input  wire logic        bus_request_n,
  output logic             bus_grant_n,
  // external memory pins
  output logic [13:0]      addr_o,
  output logic             addr_oe_n,
  input  wire logic [23:0] data_i,
  output logic [23:0]      data_o,
  output logic             data_oe_n,
  output logic             program_memory_select_n,
  output logic             data_memory_select_n,
  output logic             boot_memory_select_n,
  output logic             rd_n,
  output logic             wr_n,
  output logic             strobe_oe_n,
  // internal program memory write port
  output logic             pm_we,
  output logic [10:0]      pm_addr,
  output logic [23:0]      pm_wdata,
  output logic             booting
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_BREAD = 3'b001,
    ST_CACC  = 3'b010,
    ST_GRANT = 3'b011,
    ST_WAITR = 3'b100
  } state_t;

  state_t      state_q;
  logic        br_s1_q;
  logic        br_s2_q;
  logic        rp_s1_q;
  logic        rp_s2_q;
  logic        mm_s1_q;
  logic        mm_s2_q;
  logic        rp_prev_q;
  logic        boot_pend_q;
  logic [15:0] sysctrl_q;
  logic [14:0] zone_ws_q;
  logic        busy_boot_q;
  logic [1:0]  byte_idx_q;
  logic [15:0] byte_cnt_q;
  logic [15:0] word_acc_q;
  logic [10:0] word_cnt_q;
  logic        ws_start;
  logic [2:0]  ws_val;
  logic        ws_done;
  logic        ap_q;
  logic        ap_wr_q;
  logic [7:0]  ap_addr_q;
  logic        br_act;
  logic        boot_pick;
  logic        core_pick;
  logic [10:0] boot_words;

  // request pin and reset pin pass two flops before use
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      br_s1_q <= 1'b1;
      br_s2_q <= 1'b1;
      rp_s1_q <= 1'b0;
      rp_s2_q <= 1'b0;
      mm_s1_q <= 1'b0;
      mm_s2_q <= 1'b0;
    end else begin
      br_s1_q <= bus_request_n;
      br_s2_q <= br_s1_q;
      rp_s1_q <= reset_pin_n;
      rp_s2_q <= rp_s1_q;
      mm_s1_q <= memory_map_select;
      mm_s2_q <= mm_s1_q;
    end
  end
  assign br_act     = !br_s2_q;
  assign boot_words = 11'(BOOT_WORDS - 1);

  wait_counter u_wait (
    .clock (clock),
    .rstn  (rstn),
    .start (ws_start),
    .waits (ws_val),
    .done  (ws_done)
  );

  // ahb register slave, zero wait states
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ap_q      <= 1'b0;
      ap_wr_q   <= 1'b0;
      ap_addr_q <= 8'h00;
    end else if (hready) begin
      ap_q      <= hsel && (htrans == HTRANS_NONSEQ);
      ap_wr_q   <= hwrite;
      ap_addr_q <= haddr[7:0];
    end
  end

  // a software write wins over the force bit's self-clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sysctrl_q <= {3'h0, 1'b0, 1'b0, BOOT_WS_RESET, 8'h00};
      zone_ws_q <= {NUM_ZONES{ZONE_WS_RESET}};
    end else begin
      if (ap_q && ap_wr_q && ap_addr_q == REG_SYSCTRL)
        sysctrl_q <= hwdata[15:0];
      else if (state_q == ST_BREAD && boot_pend_q)
        sysctrl_q[SC_FORCE_BIT] <= 1'b0; // force bit self-clears once taken
      if (ap_q && ap_wr_q && ap_addr_q == REG_WAIT)
        zone_ws_q <= hwdata[14:0];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      if (hready && hsel && htrans == HTRANS_NONSEQ && !hwrite) begin
        case (haddr[7:0])
          REG_SYSCTRL: hrdata <= {16'h0000, sysctrl_q};
          REG_WAIT:    hrdata <= {17'h00000, zone_ws_q};
          REG_STATUS:  hrdata <= {27'h0, busy_boot_q, !bus_grant_n, 1'b0, byte_idx_q};
          REG_PMLAST:  hrdata <= {21'h0, pm_addr}; // last word written; count wraps
          default:     hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // boot request: reset release with map low, or software force
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rp_prev_q   <= 1'b0;
      boot_pend_q <= 1'b0;
    end else begin
      rp_prev_q <= rp_s2_q;
      if (rp_s2_q && !rp_prev_q && !mm_s2_q)
        boot_pend_q <= 1'b1;
      else if (sysctrl_q[SC_FORCE_BIT])
        boot_pend_q <= 1'b1;
      else if (state_q == ST_BREAD && byte_cnt_q == 16'h0000)
        boot_pend_q <= 1'b0;
    end
  end

  // boot byte address: page above offset; small parts use 12-bit offset
  function automatic logic [15:0] boot_addr(input logic [2:0] pg, input logic [15:0] off,
                                            input logic small_part);
    return small_part ? {1'b0, pg, off[11:0]} : {pg, off[12:0]};
  endfunction

  // on-chip data ram and control registers never reach the pins
  function automatic logic on_chip(input logic [13:0] a);
    return (a >= INT_DM_BASE && a < INT_DM_BASE + INT_DM_WORDS) || a >= CTRL_BASE;
  endfunction

  logic [15:0] baddr;
  assign baddr = boot_addr(sysctrl_q[SC_PAGE_LSB +: 3], byte_cnt_q,
                           sysctrl_q[SC_SMALL_BIT]);

  // a boot in progress keeps the core off the interface until its last word; a bus grant can still pause it
  assign boot_pick = boot_pend_q || busy_boot_q;
  // the done pulse blocks a restart while the core still holds its request
  assign core_pick = !boot_pick && core_req && !core_done
                     && (core_pm || !on_chip(core_addr));

  always_comb begin
    ws_val = sysctrl_q[SC_BOOTWS_LSB +: 3];
    if (core_pick) begin
      if (core_pm)
        ws_val = ZONE_WS_RESET;
      else
        ws_val = zone_ws_q[3*zone_of(core_addr) +: 3];
    end
  end
  assign ws_start = (state_q == ST_IDLE) && !br_act && rp_s2_q
                    && (boot_pick || core_pick);

  // main sequencer
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q     <= ST_IDLE;
      busy_boot_q <= 1'b0;
      byte_idx_q  <= 2'h0;
      byte_cnt_q  <= 16'h0000;
      word_acc_q  <= 16'h0000;
      word_cnt_q  <= 11'h000;
      pm_we       <= 1'b0;
      pm_addr     <= 11'h000;
      pm_wdata    <= 24'h000000;
      core_done   <= 1'b0;
      core_rdata  <= 24'h000000;
    end else begin
      pm_we     <= 1'b0;
      core_done <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (br_act)
            state_q <= ST_GRANT;
          else if (ws_start && boot_pick) begin
            state_q     <= ST_BREAD;
            busy_boot_q <= 1'b1;
            if (!busy_boot_q) begin
              byte_cnt_q <= 16'h0000;
              byte_idx_q <= 2'h0;
              word_cnt_q <= 11'h000;
            end
          end else if (ws_start)
            state_q <= ST_CACC;
          // on-chip data answers at once and never touches the pins
          else if (rp_s2_q && !boot_pick && core_req && !core_done && !core_pm
                   && on_chip(core_addr))
            core_done <= 1'b1;
        end
        ST_BREAD: if (ws_done) begin
          byte_cnt_q <= byte_cnt_q + 16'h0001;
          if (byte_idx_q == 2'(BYTES_PER_WORD - 1)) begin
            pm_we      <= 1'b1;
            pm_addr    <= word_cnt_q;
            pm_wdata   <= {word_acc_q, data_i[15:8]};
            byte_idx_q <= 2'h0;
            word_cnt_q <= word_cnt_q + 11'h001;
          end else begin
            byte_idx_q <= byte_idx_q + 2'h1;
            word_acc_q <= {word_acc_q[7:0], data_i[15:8]};
          end
          // the byte is complete before any grant is considered
          if (byte_idx_q == 2'(BYTES_PER_WORD - 1) && word_cnt_q == boot_words) begin
            busy_boot_q <= 1'b0;
            state_q     <= br_act ? ST_GRANT : ST_IDLE;
          end else
            state_q <= br_act ? ST_GRANT : ST_IDLE;
        end
        ST_CACC: if (ws_done) begin
          core_done  <= 1'b1;
          core_rdata <= data_i;
          // next access of the same instruction may lose the bus here
          state_q    <= br_act ? ST_GRANT : ST_IDLE;
        end
        ST_GRANT: if (!br_act)
          state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // pin drivers, all from flops; floated whenever granted
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      addr_o                  <= 14'h0000;
      data_o                  <= 24'h000000;
      addr_oe_n               <= 1'b0;
      data_oe_n               <= 1'b1;
      strobe_oe_n             <= 1'b0;
      program_memory_select_n <= 1'b1;
      data_memory_select_n    <= 1'b1;
      boot_memory_select_n    <= 1'b1;
      rd_n                    <= 1'b1;
      wr_n                    <= 1'b1;
      bus_grant_n             <= 1'b1;
      core_halt               <= 1'b0;
      booting                 <= 1'b0;
    end else begin
      bus_grant_n <= !(state_q == ST_GRANT);
      addr_oe_n   <= (state_q == ST_GRANT);
      strobe_oe_n <= (state_q == ST_GRANT);
      // no-halt mode stalls under grant only while core_req is high; a boot always stalls
      core_halt   <= (state_q == ST_GRANT || busy_boot_q)
                     && (!sysctrl_q[SC_NOHALT_BIT] || core_req || busy_boot_q);
      booting     <= busy_boot_q;
      boot_memory_select_n    <= !(state_q == ST_BREAD);
      program_memory_select_n <= !(state_q == ST_CACC && core_pm);
      data_memory_select_n    <= !(state_q == ST_CACC && !core_pm);
      rd_n      <= !(state_q == ST_BREAD || (state_q == ST_CACC && !core_write));
      wr_n      <= !(state_q == ST_CACC && core_write);
      data_oe_n <= !(state_q == ST_BREAD || (state_q == ST_CACC && core_write));
      if (state_q == ST_BREAD) begin
        addr_o <= baddr[13:0];
        data_o <= {baddr[15:14], 22'h000000};
      end else begin
        addr_o <= core_addr;
        data_o <= core_wdata;
      end
    end
  end
endmodule // boot_loader_and_bus_grant
`default_nettype wire

// ==== tb/boot_loader_and_bus_grant_sva.sv ====
// port assertions for the boot loader and bus grant block
`timescale 1ns/10ps
`default_nettype none
module boot_loader_and_bus_grant_sva (
  // clock and reset
  input wire logic        clock,
  input wire logic        rstn,
  // watched request and outputs
  input wire logic        bus_request_n,
  input wire logic        bus_grant_n,
  input wire logic [13:0] addr_o,
  input wire logic        addr_oe_n,
  input wire logic        data_oe_n,
  input wire logic        strobe_oe_n,
  input wire logic        boot_memory_select_n,
  input wire logic        rd_n,
  input wire logic        wr_n,
  input wire logic        core_done,
  input wire logic        pm_we,
  input wire logic        booting
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence boot_rd_s; !boot_memory_select_n && !rd_n; endsequence
  sequence boot_two_s; boot_rd_s ##1 boot_rd_s; endsequence
  bus_float_a: assert property (!bus_grant_n |-> addr_oe_n && data_oe_n && strobe_oe_n)
    else $error("pins driven under grant");
  // bound covers seven boot or zone waits plus request sync
  grant_soon_a: assert property ($fell(bus_request_n) |->
    ##[1:20] (!bus_grant_n || bus_request_n)) else $error("grant late");
  grant_drop_a: assert property ($rose(bus_request_n) |-> ##[1:8] bus_grant_n)
    else $error("grant held after release");
  grant_cause_a: assert property ($fell(bus_grant_n) |-> !$past(bus_request_n, 2))
    else $error("grant without request");
  boot_pins_a: assert property (boot_rd_s |-> wr_n && !data_oe_n && !addr_oe_n)
    else $error("boot read pins wrong");
  boot_page_a: assert property (boot_two_s |-> $stable(addr_o[13]))
    else $error("page bit moved in boot read");
  pack_gap_a: assert property (pm_we |=> !pm_we [*2])
    else $error("word written before three bytes");
  pack_boot_a: assert property (pm_we |-> booting)
    else $error("word written outside boot");
  done_free_a: assert property (core_done |-> bus_grant_n)
    else $error("access done while granted");
endmodule  // boot_loader_and_bus_grant_sva
bind boot_loader_and_bus_grant boot_loader_and_bus_grant_sva i_boot_loader_and_bus_grant_sva (.*);
`default_nettype wire

// ==== tb/ext_side_model.sv ====
// far side: paged boot memory, data peripherals and an external bus master
`timescale 1ns/10ps
`default_nettype none
module ext_side_model (
  // clock
  input  wire logic        clock,
  // device memory pins
  input  wire logic [13:0] addr_o,
  input  wire logic [23:0] data_o,
  input  wire logic        boot_memory_select_n,
  input  wire logic        data_memory_select_n,
  input  wire logic        rd_n,
  output logic [23:0]      data_i,
  // external master
  input  wire logic        want_bus,
  output logic             bus_request_n
);
  logic        flip_q = 1'b0;
  logic [15:0] baddr;
  assign baddr = {data_o[23:22], addr_o};
  always_ff @(posedge clock) begin
    flip_q        <= ~flip_q;
    bus_request_n <= ~want_bus;
  end
  // idle lanes toggle so a stale byte can never match
  always_comb begin
    data_i = flip_q ? 24'hA5A5A5 : 24'h5A5A5A;
    if (!boot_memory_select_n && !rd_n) data_i[15:8] = baddr[7:0] ^ baddr[15:8] ^ 8'h5A;
    else if (!data_memory_select_n && !rd_n) data_i = {addr_o, 10'h155};
  end
endmodule  // ext_side_model
`default_nettype wire

// ==== tb/boot_loader_and_bus_grant_tb_top.sv ====
// self-checking bench for the boot loader and bus grant block
`timescale 1ns/10ps
`default_nettype none
module boot_loader_and_bus_grant_tb_top import xmem_pkg::*; ;
  logic        clock = 1'b0, rstn = 1'b0, reset_pin_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        core_req = 1'b0, want_bus = 1'b0, hreadyout, hresp, core_done, core_halt;
  logic        memory_map_select = 1'b0;
  logic        bus_request_n, bus_grant_n, addr_oe_n, data_oe_n, strobe_oe_n, pm_we, booting;
  logic        data_memory_select_n, boot_memory_select_n, rd_n, wr_n;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  page = 3'h0;
  logic [10:0] pm_addr;
  logic [13:0] core_addr = 14'h0, addr_o;
  logic [15:0] ba;
  logic [23:0] data_i, data_o, pm_wdata, core_rdata;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  int          error_cnt = 0, n_compared = 0, wcnt = 0, wbase = 0, n, d0, d4;
  always #5 clock = ~clock;
  boot_loader_and_bus_grant i_boot_loader_and_bus_grant (.hsize(3'h2), .hready(hreadyout),
    .core_pm(1'b0), .core_write(1'b0), .core_wdata(24'h0), .program_memory_select_n(), .*);
  ext_side_model i_ext_side_model (.*);
  function automatic logic [7:0] bt(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // counts select-low cycles so zones compare without a fixed overhead
  task automatic core_rd(input logic [13:0] a, output int dur);
    core_addr <= a;
    core_req <= 1'b1;
    dur = 0;
    for (int k = 0; k < 60 && core_done !== 1'b1; k++) begin
      @(posedge clock);
      dur += (data_memory_select_n === 1'b0);
    end
    core_req <= 1'b0;
    if (a < INT_DM_BASE) chk("core data", {8'h0, a, 10'h155}, {8'h0, core_rdata});
    repeat (12) @(posedge clock);
  endtask
  task automatic bus_on;
    want_bus <= 1'b1;
    for (n = 0; n < 60 && bus_grant_n !== 1'b0; n++) @(posedge clock);
    chk("grant", 32'h0, {31'h0, bus_grant_n});
  endtask
  task automatic bus_off;
    want_bus <= 1'b0;
    for (int k = 0; k < 60 && bus_grant_n !== 1'b1; k++) @(posedge clock);
    @(posedge clock);
    chk("release", 32'h0, {30'h0, ~bus_grant_n, addr_oe_n});
  endtask
  task automatic complete_run;
    if (error_cnt == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clock) begin
    if (pm_we === 1'b1) begin
      ba = {page, 13'h0} + 16'(3 * (wcnt - wbase));
      chk("pm addr", 32'(wcnt - wbase), {21'h0, pm_addr});
      chk("pm word", {8'h0, bt(ba), bt(ba + 16'h1), bt(ba + 16'h2)}, {8'h0, pm_wdata});
      wcnt <= wcnt + 1;
    end
  end
  initial begin
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    ahb(1'b0, REG_SYSCTRL, 32'h0);
    chk("boot waits", 32'h3, {29'h0, r[10:8]});
    ahb(1'b0, REG_WAIT, 32'h0);
    chk("zone waits", 32'h7FFF, {17'h0, r[14:0]});
    ahb(1'b1, 8'h10, 32'hFFFFFFFF);
    ahb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, r);
    bus_on();
    reset_pin_n <= 1'b1;
    repeat (20) @(posedge clock);
    chk("boot held", 32'h0, {31'h0, booting});
    bus_off();
    for (n = 0; n < 60 && booting !== 1'b1; n++) @(posedge clock);
    chk("boot start", 32'h1, {31'h0, booting});
    repeat (300) @(posedge clock);
    bus_on();
    repeat (2) @(posedge clock);
    d0 = wcnt;
    repeat (30) @(posedge clock);
    chk("boot paused", 32'(d0), 32'(wcnt));
    bus_off();
    for (n = 0; n < 40000 && booting !== 1'b0; n++) @(posedge clock);
    ahb(1'b0, REG_PMLAST, 32'h0);
    chk("words", 32'(BOOT_WORDS - 1), r);
    chk("words seen", 32'(BOOT_WORDS), 32'(wcnt));
    page = 3'h5;
    wbase = wcnt;
    ahb(1'b1, REG_SYSCTRL, 32'h0000000D);
    for (n = 0; n < 60 && booting !== 1'b1; n++) @(posedge clock);
    ahb(1'b0, REG_SYSCTRL, 32'h0);
    chk("sysctrl", 32'h5, {19'h0, r[12:0]});
    for (n = 0; n < 20000 && booting !== 1'b0; n++) @(posedge clock);
    chk("page words", 32'(BOOT_WORDS), 32'(wcnt - wbase));
    ahb(1'b1, REG_WAIT, 32'h00005001);
    core_rd(14'h3900, n);
    chk("on-chip", 32'h0, 32'(n));
    core_rd(14'h0100, d0);
    core_rd(14'h3000, d4);
    chk("zone gap", 32'h4, 32'(d4 - d0));
    core_req <= 1'b1;
    @(posedge clock);
    want_bus <= 1'b1;
    d0 = 0;
    for (n = 0; n < 60 && bus_grant_n !== 1'b0; n++) begin
      @(posedge clock);
      if (core_done === 1'b1) d0 = 1;
      if (core_done === 1'b1) core_req <= 1'b0;
    end
    chk("done first", 32'h1, 32'(d0));
    bus_off();
    ahb(1'b1, REG_SYSCTRL, 32'h10);
    bus_on();
    chk("idle grant", 32'h1, 32'(n <= 8));
    chk("no halt", 32'h0, {31'h0, core_halt});
    core_req <= 1'b1;
    repeat (4) @(posedge clock);
    chk("stall", 32'h1, {31'h0, core_halt});
    bus_off();
    for (n = 0; n < 60 && core_done !== 1'b1; n++) @(posedge clock);
    core_req <= 1'b0;
    chk("resume", 32'h1, {31'h0, core_done});
    ahb(1'b1, REG_SYSCTRL, 32'h0);
    bus_on();
    chk("halt", 32'h1, {31'h0, core_halt});
    bus_off();
    memory_map_select <= 1'b1;
    reset_pin_n <= 1'b0;
    repeat (4) @(posedge clock);
    reset_pin_n <= 1'b1;
    repeat (20) @(posedge clock);
    chk("map boot", 32'h0, {31'h0, booting});
    complete_run();
  end
  initial begin
    repeat (90000) @(posedge clock);
    error_cnt++;
    complete_run();
  end
endmodule  // boot_loader_and_bus_grant_tb_top
`default_nettype wire
